// *** rtl/sram_ctrl_pkg.sv ***
/*
 * Shared constants and types of the burst cache memory control logic:
 * widths, reset values and the access cycle encoding.
 * Assumes a single rising-edge clock and a synchronous active-low reset.
 */
package sram_ctrl_pkg;

	// ============================================================
	// Widths
	localparam int ADDR_BITS  = 18;
	localparam int LANE_COUNT = 2;
	localparam int LANE_BITS  = 8;
	localparam int BURST_BITS = 2;

	// ============================================================
	// Values after reset and the counter step
	localparam logic [15:0] UPPER_RST = 16'h0000;
	localparam logic [1:0]  START_RST = 2'h0;
	localparam logic [1:0]  STEP_RST  = 2'h0;
	localparam logic [1:0]  STEP_ONE  = 2'h1;
	localparam logic [17:0] READ_RST  = 18'h0_0000;

	// ============================================================
	// Access cycle of the selected device
	typedef enum logic [1:0]
	{
		CYC_IDLE  = 2'b00,
		CYC_READ  = 2'b01,
		CYC_WRITE = 2'b10
	} cycle_t;

endpackage

// *** rtl/burst_if.sv ***
/*
 * Link between the access control and the burst counter.
 * Assumes both ends run on the same clock.
 */
interface burst_if
	import sram_ctrl_pkg::*;
	();

	logic                  load;
	logic [BURST_BITS-1:0] start;
	logic                  advance;
	logic                  interleave;
	logic [BURST_BITS-1:0] next_offset;

	modport ctrl
	(
		output load,
		output start,
		output advance,
		output interleave,
		input  next_offset
	);

	modport cnt
	(
		input  load,
		input  start,
		input  advance,
		input  interleave,
		output next_offset
	);

endinterface

// *** rtl/burst_counter.sv ***
/*
 * Two-bit wrap-around burst counter with interleaved or linear order.
 * Assumes load and advance never assert together; load wins if they do.
 */
module burst_counter
	import sram_ctrl_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	burst_if.cnt      bus
);

	logic [BURST_BITS-1:0] start_r;
	logic [BURST_BITS-1:0] start_nxt;
	logic [BURST_BITS-1:0] step_r;
	logic [BURST_BITS-1:0] step_nxt;

	// ============================================================
	// Burst order: xor of start for interleaved, sum for linear
	function automatic logic [BURST_BITS-1:0] burst_addr
	(
		input logic [BURST_BITS-1:0] start,
		input logic [BURST_BITS-1:0] step,
		input logic                  interleave
	);
		if (interleave)
			return start ^ step;
		return BURST_BITS'(start + step);
	endfunction

	// Preload on a strobe, step on advance, otherwise hold
	always_comb
	begin
		start_nxt = start_r;
		step_nxt  = step_r;
		if (bus.load)
		begin
			start_nxt = bus.start; // RL5
			step_nxt  = STEP_RST;
		end
		else if (bus.advance)
		begin
			step_nxt = BURST_BITS'(step_r + STEP_ONE); // RL8 RL6
		end
	end

	// Counter registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			start_r <= START_RST;
			step_r  <= STEP_RST;
		end
		else
		begin
			start_r <= start_nxt;
			step_r  <= step_nxt; // RL20
		end
	end

	// Low address bits of the coming cycle
	assign bus.next_offset = burst_addr(start_nxt, step_nxt,
		bus.interleave); // RL7 RL14

endmodule

// *** rtl/burst_sram_addr_write_ctrl.sv ***
/*
 * Burst cache memory: address strobes, chip selects, burst counter,
 * byte-lane writes and a 256K by 18 storage array behind common data pins.
 * Assumes all inputs except the output enable are synchronous to ref_clk;
 * the two-way data pins are resolved outside from the output enables.
 * Reset clears the access state and the burst counter, not the array.
 * Sleep freezes every register, so a burst resumes where it stopped.
 * A processor strobe edge is always a read; writes need the controller
 * strobe or a continuing burst.
 */
// Behaviour
// RL1: Controller strobe low loads full address
// RL2: Processor strobe low loads address, starts burst
// RL3: Both strobes low: processor strobe wins
// RL4: Processor strobe ignored while first select high
// RL5: Strobe load presets counter from low bits
// RL6: Two-bit counter wraps after four locations
// RL7: Order input high interleaved, low linear
// RL8: Advance low steps counter to next address
// RL9: Upper address taken only when fully selected
// RL10: Partner drives lane write enable low
// RL11: Lane selects write byte plus parity bit
// RL12: Writes complete internally from edge values
// RL13: Selects sampled, output enable acts asynchronously
// RL14: Device generates remaining burst addresses itself
// RL15: Storage is 256K words of 18 bits
// RL16: All-lanes write overrides byte-lane writes
// RL17: Read data from previously latched address
// RL18: Data drivers off during a write cycle
// RL19: Sleep ignores inputs, keeps contents
// RL20: Counter holds without advance or strobe
module burst_sram_addr_write_ctrl
	import sram_ctrl_pkg::*;
#(
	parameter int ADDR_W  = ADDR_BITS,
	parameter int LANES   = LANE_COUNT
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [ADDR_W-1:0]     addr_in,
	input  wire logic                  controller_addr_strobe_n,
	input  wire logic                  processor_addr_strobe_n,
	input  wire logic                  burst_advance_n,
	input  wire logic                  burst_order_interleaved,
	input  wire logic                  chip_select_first_n,
	input  wire logic                  chip_select_second,
	input  wire logic                  chip_select_third_n,
	input  wire logic                  lane_write_enable_n,
	input  wire logic [LANES-1:0]      lane_select_n,
	input  wire logic                  all_lanes_write_n,
	input  wire logic                  output_enable_n,
	input  wire logic                  sleep_request,
	input  wire logic [LANES*8-1:0]    data_in,
	output      logic [LANES*8-1:0]    data_out,
	output      logic [LANES*8-1:0]    data_oe,
	input  wire logic [LANES-1:0]      parity_lines_in,
	output      logic [LANES-1:0]      parity_lines_out,
	output      logic [LANES-1:0]      parity_lines_oe
);

	// ============================================================
	// Elaboration checks
	localparam int WORD_W = LANES * (LANE_BITS + 1);
	localparam int DEPTH  = 1 << ADDR_W;

	if (ADDR_W <= BURST_BITS || ADDR_W > 24)
	begin : g_addr_chk
		$error("address width out of range");
	end
	if (LANES < 1 || LANES > 4)
	begin : g_lane_chk
		$error("lane count out of range");
	end
	if (LANE_BITS != 8)
	begin : g_byte_chk
		$error("lane width must match the byte-wide data pins");
	end

	// ============================================================
	// Declarations
	logic [WORD_W-1:0]          mem [DEPTH];
	cycle_t                     cycle_r;
	cycle_t                     cycle_nxt;
	logic [ADDR_W-1:BURST_BITS] upper_r;
	logic [ADDR_W-1:BURST_BITS] upper_nxt;
	logic [WORD_W-1:0]          read_r;
	logic [WORD_W-1:0]          read_nxt;
	logic [ADDR_W-1:0]          acc_addr;
	logic [LANES-1:0]           write_lanes;
	logic                       awake;
	logic                       selected;
	logic                       proc_take;
	logic                       ctrl_take;
	logic                       strobe_take;
	logic                       load;
	logic                       deselect;
	logic                       continuing;
	logic                       write_now;
	logic                       drive;

	burst_if burst ();

	// ============================================================
	// Helper functions

	// Lanes written this edge; all-lanes write overrides lane writes
	function automatic logic [LANES-1:0] lane_mask
	(
		input logic             all_n,
		input logic             enable_n,
		input logic [LANES-1:0] select_n
	);
		if (!all_n)
			return '1; // RL16
		if (!enable_n)
			return ~select_n; // RL11 RL10
		return '0;
	endfunction

	// Storage word of one lane: parity bit above its data byte
	function automatic logic [LANE_BITS:0] lane_word
	(
		input logic [LANES*8-1:0] data,
		input logic [LANES-1:0]   parity,
		input int                 lane
	);
		return {parity[lane], data[lane*LANE_BITS +: LANE_BITS]};
	endfunction

	// First storage bit of a lane: a data byte with its parity bit above
	function automatic int lane_base
	(
		input int lane
	);
		return lane * (LANE_BITS + 1);
	endfunction

	// Kind of access opened by a load or a burst step
	function automatic cycle_t open_cycle
	(
		input logic writing
	);
		return writing ? CYC_WRITE : CYC_READ;
	endfunction

	// ============================================================
	// Strobe qualification

	// Sleep blocks every other input
	assign awake = !sleep_request; // RL19

	// All three chip selects active on this edge
	assign selected = !chip_select_first_n && chip_select_second &&
		!chip_select_third_n; // RL13

	// Processor strobe gated by the first chip select
	assign proc_take = awake && !processor_addr_strobe_n &&
		!chip_select_first_n; // RL4 RL2

	// Controller strobe counts only when no processor strobe is taken
	assign ctrl_take = awake && !controller_addr_strobe_n &&
		!proc_take; // RL3 RL1

	assign strobe_take = proc_take || ctrl_take;

	// Address load only with a full selection
	assign load     = strobe_take && selected; // RL9
	assign deselect = strobe_take && !selected;

	// A burst in progress with no new strobe
	assign continuing = awake && !strobe_take && (cycle_r != CYC_IDLE);

	// ============================================================
	// Write detection

	// Lane mask from the write controls
	assign write_lanes = lane_mask(all_lanes_write_n, lane_write_enable_n,
		lane_select_n);

	// A processor strobe always opens with a read
	assign write_now = awake && (|write_lanes) && !proc_take &&
		(load || continuing);

	// ============================================================
	// Burst counter link
	assign burst.load       = load; // RL5
	assign burst.start      = addr_in[BURST_BITS-1:0];
	assign burst.advance    = continuing && !burst_advance_n; // RL8
	assign burst.interleave = burst_order_interleaved; // RL7

	burst_counter u_counter
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.bus     (burst.cnt)
	);

	// Address of the cycle opened on this edge; the upper bits come from
	// the pins on a load edge so the read does not loop through upper_nxt
	assign acc_addr = {load ? addr_in[ADDR_W-1:BURST_BITS] : upper_r,
		burst.next_offset}; // RL14 RL9

	// ============================================================
	// Access control next state
	always_comb
	begin
		cycle_nxt = cycle_r;
		upper_nxt = upper_r;
		read_nxt  = read_r;
		if (load)
		begin
			upper_nxt = addr_in[ADDR_W-1:BURST_BITS]; // RL1 RL2 RL9
		end
		case (cycle_r)
			CYC_IDLE:
			begin
				// Advance and writes are refused until a selected strobe
				if (load)
				begin
					cycle_nxt = open_cycle(write_now);
				end
			end
			CYC_READ,
			CYC_WRITE:
			begin
				if (deselect)
				begin
					cycle_nxt = CYC_IDLE;
				end
				else if (load || continuing)
				begin
					cycle_nxt = open_cycle(write_now);
				end
			end
			default:
			begin
				// Unused code falls back to idle
				cycle_nxt = CYC_IDLE;
			end
		endcase
		if (!awake)
		begin
			cycle_nxt = cycle_r; // RL19
		end
		if (awake && cycle_nxt == CYC_READ)
		begin
			read_nxt = mem[acc_addr]; // RL17
		end
	end

	// Access control registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cycle_r <= CYC_IDLE;
			upper_r <= (ADDR_W-BURST_BITS)'(UPPER_RST);
			read_r  <= WORD_W'(READ_RST);
		end
		else
		begin
			cycle_r <= cycle_nxt;
			upper_r <= upper_nxt;
			read_r  <= read_nxt;
		end
	end

	// ============================================================
	// Storage array, written from values captured at the edge
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < LANES; i++)
		begin
			if (write_now && write_lanes[i])
			begin
				mem[acc_addr][lane_base(i) +: LANE_BITS+1] <=
					lane_word(data_in, parity_lines_in, i); // RL12 RL15
			end
		end
	end

	// ============================================================
	// Data pins

	// Output enable acts without the clock; writes turn drivers off
	assign drive = !output_enable_n && awake && (cycle_r == CYC_READ) &&
		!write_now; // RL13 RL18

	// Read word split into data bytes and parity bits
	always_comb
	begin
		data_out         = '0;
		parity_lines_out = '0;
		for (int i = 0; i < LANES; i++)
		begin
			data_out[i*LANE_BITS +: LANE_BITS] =
				read_r[lane_base(i) +: LANE_BITS];
			parity_lines_out[i] =
				read_r[lane_base(i) + LANE_BITS];
		end
	end

	assign data_oe         = {(LANES*LANE_BITS){drive}};
	assign parity_lines_oe = {LANES{drive}};

endmodule

// *** test/burst_ctrl_props.sv ***
/*
 * Port checker of the burst cache memory control block.
 * Bound to the top module; one clock, synchronous active-low reset.
 */
module burst_ctrl_props
#(
	parameter int LANES = 2
)
(
	input wire logic               ref_clk,
	input wire logic               rst_n,
	input wire logic               controller_addr_strobe_n,
	input wire logic               processor_addr_strobe_n,
	input wire logic               burst_advance_n,
	input wire logic               chip_select_first_n,
	input wire logic               chip_select_second,
	input wire logic               chip_select_third_n,
	input wire logic               lane_write_enable_n,
	input wire logic               all_lanes_write_n,
	input wire logic               output_enable_n,
	input wire logic               sleep_request,
	input wire logic [LANES*8-1:0] data_out,
	input wire logic [LANES*8-1:0] data_oe,
	input wire logic [LANES-1:0]   parity_lines_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Device fully selected and awake
	wire logic sel = !chip_select_first_n && chip_select_second
		&& !chip_select_third_n && !sleep_request;

	// ============================================================
	// Access sequences
	sequence ctl_read_s;
		sel && !controller_addr_strobe_n && processor_addr_strobe_n
		&& all_lanes_write_n && lane_write_enable_n
		##1 !output_enable_n && !sleep_request;
	endsequence
	sequence both_write_s;
		sel && !controller_addr_strobe_n && !processor_addr_strobe_n
		&& !all_lanes_write_n ##1 !output_enable_n && !sleep_request;
	endsequence

	// ============================================================
	// Properties
	a_read_drives: assert property (
		ctl_read_s |-> &data_oe && &parity_lines_oe)
		else $error("read data not driven");
	a_both_reads: assert property (
		both_write_s |-> &data_oe)
		else $error("write taken beside processor strobe");
	a_write_float: assert property (
		sel && !controller_addr_strobe_n && processor_addr_strobe_n
		&& !all_lanes_write_n |=> data_oe == '0 && parity_lines_oe == '0)
		else $error("drivers on in write cycle");
	a_oe_async: assert property (
		output_enable_n |-> data_oe == '0)
		else $error("drivers on with output enable high");
	a_sleep_off: assert property (
		sleep_request |-> data_oe == '0 && parity_lines_oe == '0)
		else $error("drivers on in sleep");
	a_sleep_keep: assert property (
		sleep_request |=> $stable(data_out))
		else $error("read data moved in sleep");
	a_deselect_off: assert property (
		!chip_select_second && !controller_addr_strobe_n
		&& !sleep_request |=> data_oe == '0)
		else $error("deselect left drivers on");
	a_proc_gated: assert property (
		chip_select_first_n && !processor_addr_strobe_n
		&& controller_addr_strobe_n && burst_advance_n
		&& !sleep_request && data_oe[0] |=> $stable(data_out))
		else $error("gated processor strobe was taken");
endmodule

bind burst_sram_addr_write_ctrl burst_ctrl_props #(.LANES(LANES)) i_props (.*);

// *** test/host_model.sv ***
/*
 * Processor and cache controller model: strobes, address, writes.
 * Assumes ref_clk from the bench; changes only at falling edges.
 */
module host_model
(
	input  wire logic        ref_clk,
	output      logic [17:0] addr_in,
	output      logic        controller_addr_strobe_n,
	output      logic        processor_addr_strobe_n,
	output      logic        burst_advance_n,
	output      logic        all_lanes_write_n,
	output      logic        lane_write_enable_n,
	output      logic [1:0]  lane_select_n,
	output      logic [15:0] data_in,
	output      logic [1:0]  parity_lines_in,
	input  wire logic [15:0] data_out,
	input  wire logic [15:0] data_oe,
	input  wire logic [1:0]  parity_lines_out,
	input  wire logic [1:0]  parity_lines_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [17:0] word_r;

	// Pin level: the device wins where it drives
	assign data_in = (data_oe & data_out) | (~data_oe & word_r[15:0]);
	assign parity_lines_in = (parity_lines_oe & parity_lines_out)
		| (~parity_lines_oe & word_r[17:16]);

	// Code bits: strobes, advance, all-lanes, lane enable, lanes
	task automatic drive(input logic [6:0] c, input logic [17:0] a,
		input logic [17:0] w);
		{controller_addr_strobe_n, processor_addr_strobe_n,
			burst_advance_n, all_lanes_write_n,
			lane_write_enable_n, lane_select_n} = c;
		addr_in = a;
		word_r = w;
	endtask

	// Held over one rising edge, then controls released high, address and word inverted
	task automatic step(input logic [6:0] c, input logic [17:0] a,
		input logic [17:0] w);
		@(negedge ref_clk);
		drive(c, a, w);
		@(negedge ref_clk);
		drive(7'h7f, ~a, ~w);
	endtask

	initial drive(7'h7f, '0, '0);
endmodule

// *** test/test_burst_sram_addr_write_ctrl.sv ***
/*
 * Self-checking bench of the burst cache memory control block.
 * Assumes the host model and the bound port checker.
 */
module test_burst_sram_addr_write_ctrl;
	timeunit 1ns;
	timeprecision 100ps;

	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        burst_order_interleaved = 1'b0;
	logic        chip_select_first_n = 1'b0;
	logic        chip_select_second = 1'b1;
	logic        chip_select_third_n = 1'b0;
	logic        output_enable_n = 1'b0;
	logic        sleep_request = 1'b0;
	logic [17:0] addr_in;
	logic        controller_addr_strobe_n, processor_addr_strobe_n;
	logic        burst_advance_n, lane_write_enable_n, all_lanes_write_n;
	logic [1:0]  lane_select_n, parity_lines_in;
	logic [1:0]  parity_lines_out, parity_lines_oe;
	logic [15:0] data_in, data_out, data_oe;
	wire  [17:0] rd_word = {parity_lines_out, data_out};
	logic [17:0] mem_m [int];
	int          err_total = 0;
	int          n_checks = 0;
	int          cycles = 0;

	burst_sram_addr_write_ctrl i_dut (.*);
	host_model host (.*);

	// ============================================================
	// Clock and run limit
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			end_of_test();
		end
	end

	// Compare and count
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, got, exp);
		end
	endtask

	// Counts and verdict
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Four-beat burst from a, linear or interleaved, write or read
	task automatic t_burst(input logic ord, input logic wr,
		input logic [17:0] a);
		logic [17:0] x;
		burst_order_interleaved = ord;
		for (int k = 0; k < 4; k++)
		begin
			x = {a[17:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
			if (wr)
				mem_m[x] = {x[1:0], ~x[15:0]};
			host.step({k != 0, 1'b1, k == 0, !wr, 3'h7}, a, mem_m[x]);
			if (wr)
				check({parity_lines_oe, data_oe}, '0);
			else
				check(rd_word, mem_m[x]);
		end
	endtask

	// Byte lanes against lane enable and all-lanes write
	task automatic t_lanes();
		logic [6:0]  c [4] = '{7'h3a, 7'h39, 7'h3b, 7'h33};
		logic [17:0] m [4] = '{18'h1_00ff, 18'h2_ff00,
			18'h0_0000, 18'h3_ffff};
		logic [17:0] a = 18'h1_0200;
		mem_m[a] = 18'h2_5a3c;
		host.step(7'h37, a, mem_m[a]);
		for (int i = 0; i < 4; i++)
		begin
			host.step(c[i], a, ~mem_m[a]);
			mem_m[a] = mem_m[a] ^ m[i];
			host.step(7'h3f, a, '0);
			check(rd_word, mem_m[a]);
		end
	endtask

	// Strobe priority, select gating and output enable
	task automatic t_strobes();
		host.step(7'h5f, 18'h0_0122, '0);
		check({parity_lines_out, data_out}, mem_m[18'h0_0122]);
		host.step(7'h17, 18'h0_0121, ~mem_m[18'h0_0121]);
		check({parity_lines_out, data_out}, mem_m[18'h0_0121]);
		chip_select_first_n = 1'b1;
		host.step(7'h5f, 18'h0_0122, '0);
		check({parity_lines_out, data_out}, mem_m[18'h0_0121]);
		chip_select_first_n = 1'b0;
		output_enable_n = 1'b1;
		#1 check({parity_lines_oe, data_oe}, '0);
		@(negedge ref_clk);
		output_enable_n = 1'b0;
		#1 check({parity_lines_oe, data_oe}, '1);
		chip_select_second = 1'b0;
		host.step(7'h3f, 18'h0_0122, '0);
		check({parity_lines_oe, data_oe}, '0);
		chip_select_second = 1'b1;
	endtask

	// Sleep ignores a write and keeps the array
	task automatic t_sleep();
		host.step(7'h3f, 18'h0_0121, '0);
		sleep_request = 1'b1;
		host.step(7'h37, 18'h0_0121, ~mem_m[18'h0_0121]);
		check({parity_lines_oe, data_oe}, '0);
		host.step(7'h3f, 18'h0_0122, '0);
		check(rd_word, mem_m[18'h0_0121]);
		sleep_request = 1'b0;
		host.step(7'h3f, 18'h0_0121, '0);
		check({parity_lines_out, data_out}, mem_m[18'h0_0121]);
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		t_burst(1'b0, 1'b1, 18'h0_0121);
		t_burst(1'b1, 1'b0, 18'h0_0121);
		t_burst(1'b1, 1'b1, 18'h2_4567);
		t_burst(1'b0, 1'b0, 18'h2_4567);
		t_lanes();
		t_strobes();
		t_sleep();
		end_of_test();
	end
endmodule
